// *** hdl/sai_pkg.sv ***
package sai_pkg;

	// ----------------------------------------------------------------
	// Framing constants
	// ----------------------------------------------------------------
	localparam int SLOT_BITS = 32;
	localparam int SAMPLE_BITS = 24;
	localparam int POS_W = 6;
	localparam logic [POS_W-1:0] POS_MAX = 6'h3F;
	localparam logic [6:0] STD_FIRST_POS = 7'h01;
	localparam logic [6:0] LEFT_FIRST_POS = 7'h00;
	localparam logic LEFT_LEVEL_STANDARD = 1'b0;
	localparam logic LEFT_LEVEL_ALIGNED = 1'b1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		STANDARD_FORMAT,
		LEFT_ALIGNED_FORMAT,
		RIGHT_ALIGNED_FORMAT
	} sai_format_type;

	typedef struct packed {
		logic [SAMPLE_BITS-1:0] left;
		logic [SAMPLE_BITS-1:0] right;
	} sai_pair_type;

endpackage

// *** hdl/sai_buf.sv ***
`timescale 1ns/100ps
`default_nettype none

// Small first-in first-out buffer held in flip-flops.
module sai_buf #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != FULL);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (push && !pop) begin
			cnt_q <= cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule

`default_nettype wire

// *** hdl/sai_rx.sv ***
`timescale 1ns/100ps
`default_nettype none

// Serial audio input receiver. The link side runs on the bit clock; finished
// sample pairs cross to core_clk by a toggle and wait in a two-entry buffer.
module sai_rx #(
	parameter int SAMPLE_W = sai_pkg::SAMPLE_BITS
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sai_bclk,
	input wire logic sai_ws,
	input wire logic sai_data,
	input wire sai_pkg::sai_format_type cfg_format,
	output logic pair_valid,
	input wire logic pair_ready,
	output sai_pkg::sai_pair_type pair_data,
	output logic overrun
);

	localparam logic [6:0] SAMPLE_LEN = 7'(SAMPLE_W);
	localparam logic [6:0] RIGHT_FIRST_POS = 7'(sai_pkg::SLOT_BITS - SAMPLE_W);
	localparam logic [6:0] LAST_POS = 7'(sai_pkg::SLOT_BITS - 1);
	localparam int SB = sai_pkg::SAMPLE_BITS;

	// ----------------------------------------------------------------
	// Bit-clock domain reset
	// ----------------------------------------------------------------
	// Reset asserts at once but is released on a bit-clock edge, so no flop
	// of the link side sees the release too close to its clock.
	logic brst_meta_q;
	logic brst_q;

	always_ff @(posedge sai_bclk or posedge rst) begin
		if (rst) begin
			brst_meta_q <= 1'b1;
			brst_q <= 1'b1;
		end else begin
			brst_meta_q <= 1'b0;
			brst_q <= brst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Link input synchronisers
	// ----------------------------------------------------------------
	// Word select and data pass the same two stages, so their relative
	// timing is kept and bit positions are unchanged.
	logic ws_meta_q;
	logic ws_q;
	logic data_meta_q;
	logic data_q;
	logic [1:0] fmt_meta_q;
	logic [1:0] fmt_q;

	always_ff @(posedge sai_bclk or posedge brst_q) begin
		if (brst_q) begin
			ws_meta_q <= 1'b0;
			ws_q <= 1'b0;
			data_meta_q <= 1'b0;
			data_q <= 1'b0;
		end else begin
			ws_meta_q <= sai_ws;
			ws_q <= ws_meta_q;
			data_meta_q <= sai_data;
			data_q <= data_meta_q;
		end
	end

	always_ff @(posedge sai_bclk or posedge brst_q) begin
		if (brst_q) begin
			fmt_meta_q <= '0;
			fmt_q <= '0;
		end else begin
			fmt_meta_q <= cfg_format;
			fmt_q <= fmt_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Bit position and capture window
	// ----------------------------------------------------------------
	logic ws_prev_q;
	logic [2:0] ws_fill_q;
	logic [sai_pkg::POS_W-1:0] pos_q;
	logic toggle;
	logic [sai_pkg::POS_W-1:0] cur_pos;
	logic [6:0] first_pos;
	logic left_lvl;
	logic in_win;
	logic old_left;

	always_comb begin
		toggle = (ws_q != ws_prev_q) && ws_fill_q[2];
		if (toggle) begin
			cur_pos = '0;
		end else if (pos_q == sai_pkg::POS_MAX) begin
			cur_pos = pos_q;
		end else begin
			cur_pos = pos_q + 1'b1;
		end
		case (sai_pkg::sai_format_type'(fmt_q))
			sai_pkg::LEFT_ALIGNED_FORMAT: begin
				first_pos = sai_pkg::LEFT_FIRST_POS;
				left_lvl = sai_pkg::LEFT_LEVEL_ALIGNED;
			end
			sai_pkg::RIGHT_ALIGNED_FORMAT: begin
				first_pos = RIGHT_FIRST_POS;
				left_lvl = sai_pkg::LEFT_LEVEL_ALIGNED;
			end
			default: begin
				first_pos = sai_pkg::STD_FIRST_POS;
				left_lvl = sai_pkg::LEFT_LEVEL_STANDARD;
			end
		endcase
		// Positions outside the window are masked in every format.
		in_win = ({1'b0, cur_pos} >= first_pos) &&
			({1'b0, cur_pos} < first_pos + SAMPLE_LEN);
		old_left = (ws_prev_q == left_lvl);
	end

	always_ff @(posedge sai_bclk or posedge brst_q) begin
		if (brst_q) begin
			ws_prev_q <= 1'b0;
			pos_q <= '0;
		end else begin
			ws_prev_q <= ws_q;
			pos_q <= cur_pos;
		end
	end

	// A word-select edge only counts once ws_q and ws_prev_q both hold real
	// samples. The reset value may differ from the idle level on the pin, and
	// that false edge would otherwise start a half too early.
	always_ff @(posedge sai_bclk or posedge brst_q) begin
		if (brst_q) begin
			ws_fill_q <= '0;
		end else begin
			ws_fill_q <= {ws_fill_q[1:0], 1'b1};
		end
	end

	// ----------------------------------------------------------------
	// Shift register and channel assembly
	// ----------------------------------------------------------------
	// The half in progress at reset release is partial; nothing is kept
	// until the first word-select edge has been seen.
	logic started_q;
	logic [SB-1:0] sh_q;
	logic [SB-1:0] left_q;
	logic have_left_q;
	sai_pkg::sai_pair_type link_pair_q;
	logic req_tgl_q;

	always_ff @(posedge sai_bclk or posedge brst_q) begin
		if (brst_q) begin
			sh_q <= '0;
		end else if (toggle) begin
			sh_q <= in_win ? {{(SB - 1){1'b0}}, data_q} : '0;
		end else if (in_win) begin
			sh_q <= {sh_q[SB-2:0], data_q};
		end
	end

	always_ff @(posedge sai_bclk or posedge brst_q) begin
		if (brst_q) begin
			started_q <= 1'b0;
		end else if (toggle) begin
			started_q <= 1'b1;
		end
	end

	always_ff @(posedge sai_bclk or posedge brst_q) begin
		if (brst_q) begin
			left_q <= '0;
			have_left_q <= 1'b0;
			link_pair_q <= '0;
			req_tgl_q <= 1'b0;
		end else if (toggle && started_q) begin
			if (old_left) begin
				left_q <= sh_q;
				have_left_q <= 1'b1;
			end else begin
				have_left_q <= 1'b0;
				if (have_left_q) begin
					link_pair_q.left <= left_q;
					link_pair_q.right <= sh_q;
					req_tgl_q <= ~req_tgl_q;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Crossing to core_clk
	// ----------------------------------------------------------------
	// The pair register changes only once per frame, 64 bit clocks apart,
	// so it is stable long before the synchronised toggle is seen here.
	logic req_meta_q;
	logic req_s_q;
	logic req_seen_q;
	logic new_pair;
	logic pend_q;
	sai_pkg::sai_pair_type pend_data_q;
	logic buf_in_ready;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			req_meta_q <= 1'b0;
			req_s_q <= 1'b0;
			req_seen_q <= 1'b0;
		end else begin
			req_meta_q <= req_tgl_q;
			req_s_q <= req_meta_q;
			req_seen_q <= req_s_q;
		end
	end

	assign new_pair = req_s_q ^ req_seen_q;

	// A pair waits here while the buffer is full; if the next pair arrives
	// first, the waiting one is overwritten and overrun pulses.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pend_q <= 1'b0;
			pend_data_q <= '0;
		end else if (new_pair) begin
			pend_q <= 1'b1;
			pend_data_q <= link_pair_q;
		end else if (pend_q && buf_in_ready) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			overrun <= 1'b0;
		end else begin
			overrun <= new_pair && pend_q && !buf_in_ready;
		end
	end

	sai_buf #(
		.WIDTH($bits(sai_pkg::sai_pair_type)),
		.DEPTH(2)
	) u_buf (
		.clk(core_clk),
		.rst(rst),
		.in_valid(pend_q),
		.in_ready(buf_in_ready),
		.in_data(pend_data_q),
		.out_valid(pair_valid),
		.out_ready(pair_ready),
		.out_data(pair_data)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_STD_SKIP_FIRST: assert property (@(posedge sai_bclk) disable iff (brst_q)
		(fmt_q == sai_pkg::STANDARD_FORMAT && toggle) |-> !in_win ##1 (!toggle -> in_win))
		else $error("standard format window does not start one bit after the edge");

	AST_LEFT_AT_EDGE: assert property (@(posedge sai_bclk) disable iff (brst_q)
		(fmt_q == sai_pkg::LEFT_ALIGNED_FORMAT && toggle) |-> in_win)
		else $error("left-aligned MSB not taken at the word-select edge");

	AST_RIGHT_FIRST: assert property (@(posedge sai_bclk) disable iff (brst_q)
		(fmt_q == sai_pkg::RIGHT_ALIGNED_FORMAT && {1'b0, cur_pos} == RIGHT_FIRST_POS)
		|-> in_win)
		else $error("right-aligned first bit not taken at its position");

	AST_RIGHT_LEAD: assert property (@(posedge sai_bclk) disable iff (brst_q)
		(fmt_q == sai_pkg::RIGHT_ALIGNED_FORMAT && {1'b0, cur_pos} < RIGHT_FIRST_POS)
		|-> !in_win)
		else $error("right-aligned leading bit not masked");

	AST_RIGHT_LSB: assert property (@(posedge sai_bclk) disable iff (brst_q)
		(fmt_q == sai_pkg::RIGHT_ALIGNED_FORMAT && {1'b0, cur_pos} == LAST_POS)
		|-> in_win)
		else $error("right-aligned LSB position not captured");

	AST_TRAIL_MASK: assert property (@(posedge sai_bclk) disable iff (brst_q)
		(fmt_q != sai_pkg::RIGHT_ALIGNED_FORMAT && {1'b0, cur_pos} >= first_pos + SAMPLE_LEN)
		|=> $stable(sh_q) || $past(toggle))
		else $error("trailing bit changed the captured word");

	AST_MSB_SHIFT: assert property (@(posedge sai_bclk) disable iff (brst_q)
		(in_win && !toggle) |=> sh_q[0] == $past(data_q) && sh_q[SB-1:1] == $past(sh_q[SB-2:0]))
		else $error("data bit not shifted in MSB first");

	AST_LEFT_STORE: assert property (@(posedge sai_bclk) disable iff (brst_q)
		(toggle && started_q && ws_prev_q == left_lvl) |=> left_q == $past(sh_q) && have_left_q)
		else $error("left half not stored by word-select polarity");

	AST_FORMAT_POLARITY: assert property (@(posedge sai_bclk) disable iff (brst_q)
		left_lvl == (fmt_q == sai_pkg::LEFT_ALIGNED_FORMAT ||
		fmt_q == sai_pkg::RIGHT_ALIGNED_FORMAT))
		else $error("left-channel level does not follow the format");

	AST_PAIR_QUEUED: assert property (@(posedge core_clk) disable iff (rst)
		new_pair |=> pend_q && pend_data_q == $past(link_pair_q))
		else $error("finished pair not queued one cycle after it arrived");

	COV_PAIR_OUT: cover property (@(posedge core_clk) disable iff (rst)
		pair_valid && pair_ready);
	COV_BUF_FULL: cover property (@(posedge core_clk) disable iff (rst)
		pend_q && !buf_in_ready);
	COV_RIGHT_PAIR: cover property (@(posedge sai_bclk) disable iff (brst_q)
		fmt_q == sai_pkg::RIGHT_ALIGNED_FORMAT && toggle && have_left_q);
	COV_LEFT_PAIR: cover property (@(posedge sai_bclk) disable iff (brst_q)
		fmt_q == sai_pkg::LEFT_ALIGNED_FORMAT && toggle && have_left_q);

endmodule

`default_nettype wire

// *** tb/sai_src.sv ***
`timescale 1ns/100ps
`default_nettype none

// --------------------------------------------------------------------
// Upstream audio source model
// --------------------------------------------------------------------
// Word select and data change after the falling bit-clock edge, so the
// receiver sees them settled at the rising edge.
module sai_src (
	input wire logic sai_bclk,
	input wire sai_pkg::sai_format_type fmt,
	output logic sai_ws,
	output logic sai_data
);
	logic [63:0] sent[$];
	logic left_lvl;

	assign left_lvl = (fmt == sai_pkg::LEFT_ALIGNED_FORMAT) ||
		(fmt == sai_pkg::RIGHT_ALIGNED_FORMAT);

	initial begin
		sai_ws = 1'b0;
		sai_data = 1'b0;
	end

	// Idle data flips every bit so that a stale level never passes for data.
	task automatic idle(input int n, input logic lvl);
		repeat (n) begin
			@(negedge sai_bclk);
			sai_ws <= lvl;
			sai_data <= ~sai_data;
		end
	endtask

	task automatic send_half(input logic lvl, input logic [31:0] slot);
		for (int p = 0; p < 32; p++) begin
			@(negedge sai_bclk);
			sai_ws <= lvl;
			sai_data <= slot[31-p];
		end
	endtask

	// A trailing left half supplies the edge that closes the last pair.
	task automatic play(input int n);
		logic [31:0] l;
		logic [31:0] r;
		idle(4, ~left_lvl);
		repeat (n) begin
			l = $urandom;
			r = $urandom;
			send_half(left_lvl, l);
			send_half(~left_lvl, r);
			sent.push_back({l, r});
		end
		send_half(left_lvl, $urandom);
	endtask
endmodule

`default_nettype wire

// *** tb/tb_sai_rx.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_sai_rx;
	logic core_clk;
	logic rst;
	logic sai_bclk;
	logic sai_ws;
	logic sai_data;
	logic pair_valid;
	logic pair_ready;
	logic overrun;
	logic stall;
	logic strobe_chk;
	logic took_q;
	sai_pkg::sai_format_type cfg_format;
	sai_pkg::sai_pair_type pair_data;
	int n_fail;
	int n_checks;
	int n_ovr;

	sai_rx #(.SAMPLE_W(sai_pkg::SAMPLE_BITS)) sai_rx_i (
		.core_clk(core_clk),
		.rst(rst),
		.sai_bclk(sai_bclk),
		.sai_ws(sai_ws),
		.sai_data(sai_data),
		.cfg_format(cfg_format),
		.pair_valid(pair_valid),
		.pair_ready(pair_ready),
		.pair_data(pair_data),
		.overrun(overrun)
	);

	sai_src sai_src_i (
		.sai_bclk(sai_bclk),
		.fmt(cfg_format),
		.sai_ws(sai_ws),
		.sai_data(sai_data)
	);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	initial begin
		sai_bclk = 1'b0;
		#13;
		forever #40 sai_bclk = ~sai_bclk;
	end

	// ----------------------------------------------------------------
	// Expectations and reporting
	// ----------------------------------------------------------------
	function automatic logic [23:0] slot_value(input sai_pkg::sai_format_type f,
		input logic [31:0] w);
		case (f)
			sai_pkg::LEFT_ALIGNED_FORMAT: return w[31:8];
			sai_pkg::RIGHT_ALIGNED_FORMAT: return w[23:0];
			default: return w[30:7];
		endcase
	endfunction

	function automatic sai_pkg::sai_pair_type expect_pair(input sai_pkg::sai_format_type f,
		input logic [63:0] s);
		sai_pkg::sai_pair_type p;
		p.left = slot_value(f, s[63:32]);
		p.right = slot_value(f, s[31:0]);
		return p;
	endfunction

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Consumer side
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		pair_ready <= #1 stall ? 1'b0 : (strobe_chk ? 1'b1 : ($urandom_range(3) != 0));
		if (overrun === 1'b1) n_ovr++;
		if (strobe_chk && took_q) check("pair_valid", {47'h0, pair_valid}, 48'h0);
		took_q = !rst && pair_valid === 1'b1 && pair_ready === 1'b1;
		if (took_q) begin
			if (sai_src_i.sent.size() == 0) check("pending pairs", 48'h0, 48'h1);
			else check("pair_data", pair_data,
				expect_pair(cfg_format, sai_src_i.sent.pop_front()));
		end
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	// Reset is held 16 cycles. The link side clears at once and lets go two
	// bit-clock edges after rst falls, well before the source leaves idle.
	task automatic do_reset(input sai_pkg::sai_format_type f);
		@(posedge core_clk);
		#1 rst = 1'b1;
		cfg_format = f;
		repeat (16) @(posedge core_clk);
		#1 check("reset outputs", {pair_valid, overrun, 46'h0}, 48'h0);
		check("reset pair_data", pair_data, 48'h0);
		rst = 1'b0;
		n_ovr = 0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic drain(input int n_over);
		for (int i = 0; i < 3000 && sai_src_i.sent.size() != 0; i++) @(posedge core_clk);
		repeat (4) @(posedge core_clk);
		check("overrun count", 48'(n_ovr), 48'(n_over));
		if (sai_src_i.sent.size() != 0) begin
			check("pending pairs", 48'(sai_src_i.sent.size()), 48'h0);
			tally_and_finish();
		end
	endtask

	initial begin
		void'($urandom(87));
		rst = 1'b1;
		cfg_format = sai_pkg::STANDARD_FORMAT;
		pair_ready = 1'b0;
		stall = 1'b0;
		strobe_chk = 1'b0;
		took_q = 1'b0;
		n_fail = 0;
		n_checks = 0;
		n_ovr = 0;
		// Code 3 is an unlisted format and must fall back to the standard framing.
		for (int k = 0; k < 4; k++) begin
			do_reset(sai_pkg::sai_format_type'(2'(k)));
			strobe_chk = (k == 0);
			sai_src_i.play(5);
			drain(0);
		end
		strobe_chk = 1'b0;
		// With the reader stalled, three pairs are held; a fourth overwrites the waiting one.
		for (int s = 3; s < 5; s++) begin
			do_reset(sai_pkg::RIGHT_ALIGNED_FORMAT);
			stall = 1'b1;
			sai_src_i.play(s);
			repeat (100) @(posedge core_clk);
			if (s == 4) sai_src_i.sent.delete(2);
			stall = 1'b0;
			drain(s - 3);
		end
		tally_and_finish();
	end
endmodule

`default_nettype wire
